// file: hw/epf_top.sv
/*
  Interrupt flag bookkeeping for two external lines and the first peripheral
  flag bank, reached over APB.
  Assumes peripheral event inputs are one-cycle pulses or levels on CORE_CLK,
  and external pins are asynchronous.
*/
// Implementation choices: the placing of the registers and the APB slave port.
`default_nettype none


module epf_top
#(
  parameter bit HAS_PARALLEL_PORT = 1'b1
)
(
  // Clock, enable and reset.
  input  wire logic        CORE_CLK,
  input  wire logic        CORE_CE,
  input  wire logic        NRST,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // External interrupt pins.
  input  wire logic        EXT_LINE_A_PIN,
  input  wire logic        EXT_LINE_B_PIN,
  // Peripheral events.
  input  wire logic        PARPORT_ACCESS,
  input  wire logic        CONV_DONE,
  input  wire logic        RX_BUF_FULL,
  input  wire logic        TX_BUF_EMPTY,
  input  wire logic        SYNC_DONE,
  input  wire epf_pkg::epf_cc_mode_t CC_MODE,
  input  wire logic        CC_CAPTURE,
  input  wire logic        CC_MATCH,
  input  wire logic        PERIOD_MATCH,
  input  wire logic        TIMER_OVERFLOW,
  // Requests.
  output logic             EXT_REQ_HIGH,
  output logic             EXT_REQ_LOW,
  output logic [7:0]       PERIPH_FLAGS_A
);

  import epf_pkg::*;

  // ************************************************************
  // Pin synchronisers and edge detection.
  // ************************************************************
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end
    else if (CORE_CE)
    begin
      pin_meta_q <= {EXT_LINE_B_PIN, EXT_LINE_A_PIN};
      pin_sync_q <= pin_meta_q;
    end
  end

  epf_evt_if evt ();
  assign evt.level = pin_sync_q;

  epf_edge_detect u_edge
  (
    .clk  (CORE_CLK),
    .nrst (NRST),
    .ce   (CORE_CE),
    .evt  (evt)
  );

  // ************************************************************
  // APB slave.
  // ************************************************************
  epf_bus_state_t bus_q;
  logic           wr_en;
  logic           rd_en;
  logic           addr_ok;
  logic [7:0]     wbyte;
  logic [31:0]    rdata_d;

  assign addr_ok = (PADDR == EPF_OFS_EXT_CTRL) || (PADDR == EPF_OFS_PERIPH_A) ||
                   (PADDR == EPF_OFS_PERIPH_B) || (PADDR == EPF_OFS_STATUS);
  // A write lands only at the edge where the master samples PREADY high.
  assign wr_en = CORE_CE && PSEL && PENABLE && PREADY && (bus_q == EPF_BUS_ACCESS) &&
                 PWRITE && addr_ok && PSTRB[0];
  assign rd_en = CORE_CE && PSEL && PENABLE && !PREADY && !PWRITE;
  assign wbyte = PWDATA[7:0];

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      bus_q   <= EPF_BUS_IDLE;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else if (CORE_CE)
    begin
      case (bus_q)
        EPF_BUS_IDLE:
        begin
          PREADY  <= 1'b0;
          PSLVERR <= 1'b0;
          if (PSEL && PENABLE)
          begin
            bus_q   <= EPF_BUS_ACCESS;
            PREADY  <= 1'b1;
            PSLVERR <= !addr_ok;
          end
        end
        EPF_BUS_ACCESS:
        begin
          bus_q   <= EPF_BUS_IDLE;
          PREADY  <= 1'b0;
          PSLVERR <= 1'b0;
        end
        default:
        begin
          bus_q <= EPF_BUS_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // External line control register.
  // ************************************************************
  logic [7:0] ext_ctrl_q;
  logic [1:0] ext_flag_set;
  logic [1:0] ext_en;
  logic [1:0] ext_prio;
  logic       ext_wr;

  assign ext_wr       = wr_en && (PADDR == EPF_OFS_EXT_CTRL);
  assign ext_flag_set = evt.event_pulse & {2{CORE_CE}};
  assign ext_en       = {ext_ctrl_q[EPF_EXT_B_EN_BIT], ext_ctrl_q[EPF_EXT_A_EN_BIT]};
  assign ext_prio     = {ext_ctrl_q[EPF_EXT_B_PRIO_BIT], ext_ctrl_q[EPF_EXT_A_PRIO_BIT]};

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      ext_ctrl_q <= EPF_EXT_CTRL_RESET;
    else if (CORE_CE)
    begin
      if (ext_wr)
        ext_ctrl_q <= wbyte & EPF_EXT_CTRL_MASK;
      // Set wins over a clear written in the same cycle.
      if (ext_flag_set[0])
        ext_ctrl_q[EPF_EXT_A_FLAG_BIT] <= 1'b1;
      if (ext_flag_set[1])
        ext_ctrl_q[EPF_EXT_B_FLAG_BIT] <= 1'b1;
    end
  end

  // ************************************************************
  // Peripheral flag bank A.
  // ************************************************************
  logic [7:0] pa_q;
  logic [7:0] pa_set;
  logic [7:0] pa_read;
  logic       pa_wr;
  logic       cc_event;

  assign pa_wr = wr_en && (PADDR == EPF_OFS_PERIPH_A);

  always_comb
  begin
    cc_event = 1'b0;
    case (CC_MODE)
      EPF_CC_CAPTURE: cc_event = CC_CAPTURE;
      EPF_CC_COMPARE: cc_event = CC_MATCH;
      default:        cc_event = 1'b0;
    endcase
  end

  assign pa_set = {PARPORT_ACCESS & HAS_PARALLEL_PORT, CONV_DONE, 2'b00,
                   SYNC_DONE, cc_event, PERIOD_MATCH, TIMER_OVERFLOW};

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      pa_q <= EPF_PA_RESET;
    else if (CORE_CE)
      // Writes touch only software-clearable bits; events win over the write.
      pa_q <= (pa_wr ? (wbyte & EPF_PA_SW_MASK) : pa_q) | pa_set;
  end

  always_comb
  begin
    pa_read = pa_q & EPF_PA_SW_MASK;
    pa_read[EPF_PA_RX_BIT] = RX_BUF_FULL;
    pa_read[EPF_PA_TX_BIT] = TX_BUF_EMPTY;
    if (!HAS_PARALLEL_PORT)
      pa_read[EPF_PA_PARPORT_BIT] = 1'b0;
  end

  // ************************************************************
  // Read data and outputs.
  // ************************************************************
  always_comb
  begin
    rdata_d = 32'h0;
    case (PADDR)
      EPF_OFS_EXT_CTRL: rdata_d = {24'h0, ext_ctrl_q};
      EPF_OFS_PERIPH_A: rdata_d = {24'h0, pa_read};
      EPF_OFS_PERIPH_B: rdata_d = {24'h0, EPF_PB_RESET};
      EPF_OFS_STATUS:   rdata_d = {30'h0, pin_sync_q};
      default:          rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      PRDATA         <= 32'h0;
      EXT_REQ_HIGH   <= 1'b0;
      EXT_REQ_LOW    <= 1'b0;
      PERIPH_FLAGS_A <= 8'h0;
    end
    else if (CORE_CE)
    begin
      if (rd_en)
        PRDATA <= rdata_d;
      EXT_REQ_HIGH <= |({ext_ctrl_q[EPF_EXT_B_FLAG_BIT], ext_ctrl_q[EPF_EXT_A_FLAG_BIT]}
                        & ext_en & ext_prio);
      EXT_REQ_LOW  <= |({ext_ctrl_q[EPF_EXT_B_FLAG_BIT], ext_ctrl_q[EPF_EXT_A_FLAG_BIT]}
                        & ext_en & ~ext_prio);
      PERIPH_FLAGS_A <= pa_read;
    end
  end

endmodule

`default_nettype wire

// file: common/epf_pkg.sv
/*
  Package for the external-line and peripheral interrupt flag block: register
  offsets, field positions, reset values and enumerations.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
`default_nettype none

package epf_pkg;

  // ************************************************************
  // Register byte offsets.
  // ************************************************************
  localparam logic [7:0] EPF_OFS_EXT_CTRL   = 8'h00;
  localparam logic [7:0] EPF_OFS_PERIPH_A   = 8'h04;
  localparam logic [7:0] EPF_OFS_PERIPH_B   = 8'h08;
  localparam logic [7:0] EPF_OFS_STATUS     = 8'h0c;

  // ************************************************************
  // External line control field positions.
  // ************************************************************
  localparam int EPF_EXT_B_PRIO_BIT = 7;
  localparam int EPF_EXT_A_PRIO_BIT = 6;
  localparam int EPF_EXT_B_EN_BIT   = 4;
  localparam int EPF_EXT_A_EN_BIT   = 3;
  localparam int EPF_EXT_B_FLAG_BIT = 1;
  localparam int EPF_EXT_A_FLAG_BIT = 0;
  localparam logic [7:0] EPF_EXT_CTRL_MASK  = 8'hdb;
  localparam logic [7:0] EPF_EXT_CTRL_RESET = 8'hc0;

  // ************************************************************
  // Peripheral flag bank A field positions.
  // ************************************************************
  localparam int EPF_PA_PARPORT_BIT = 7;
  localparam int EPF_PA_CONV_BIT    = 6;
  localparam int EPF_PA_RX_BIT      = 5;
  localparam int EPF_PA_TX_BIT      = 4;
  localparam int EPF_PA_SYNC_BIT    = 3;
  localparam int EPF_PA_CAPCMP_BIT  = 2;
  localparam int EPF_PA_PERIOD_BIT  = 1;
  localparam int EPF_PA_TIMER_BIT   = 0;
  localparam logic [7:0] EPF_PA_SW_MASK = 8'hcf;
  localparam logic [7:0] EPF_PA_RESET   = 8'h00;
  localparam logic [7:0] EPF_PB_RESET   = 8'h00;

  // ************************************************************
  // Capture/compare unit modes.
  // ************************************************************
  typedef enum logic [1:0]
  {
    EPF_CC_OFF     = 2'b00,
    EPF_CC_CAPTURE = 2'b01,
    EPF_CC_COMPARE = 2'b10,
    EPF_CC_PWM     = 2'b11
  } epf_cc_mode_t;

  // ************************************************************
  // APB slave states.
  // ************************************************************
  typedef enum logic [0:0]
  {
    EPF_BUS_IDLE   = 1'b0,
    EPF_BUS_ACCESS = 1'b1
  } epf_bus_state_t;

endpackage

`default_nettype wire

// file: common/epf_evt_if.sv
/*
  Interface carrying the synchronised external line levels into the edge
  detector and the one-cycle event pulses back out.
  Assumes one clock shared by both ends.
*/
`default_nettype none

interface epf_evt_if;
  logic [1:0] level;
  logic [1:0] event_pulse;

  modport detect
  (
    input  level,
    output event_pulse
  );

  modport user
  (
    output level,
    input  event_pulse
  );
endinterface

`default_nettype wire

// file: hw/epf_edge_detect.sv
/*
  Rising-edge detector for the two synchronised external interrupt lines.
  Assumes its inputs are already in the clock domain.
*/
`default_nettype none

module epf_edge_detect
(
  // Clock and reset.
  input  wire logic   clk,
  input  wire logic   nrst,
  input  wire logic   ce,
  // Line levels and events.
  epf_evt_if.detect   evt
);

  logic [1:0] prev_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prev_q <= 2'h0;
    else if (ce)
      prev_q <= evt.level;
  end

  assign evt.event_pulse = evt.level & ~prev_q;

endmodule

`default_nettype wire

// file: verification/epf_periph_model.sv
/*
  Far-side model of the peripheral event sources and serial buffers.
  Assumes the bench requests events one clock ahead on CORE_CLK.
*/
`default_nettype none

module epf_periph_model
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       nrst,
  // Requests: fire bits 6..0, uart {tx wr, tx done, rx rd, rx in}.
  input  wire logic [6:0] fire,
  input  wire logic [3:0] uart,
  // Events towards the block.
  output logic      [6:0] pulse,
  output logic            rx_full,
  output logic            tx_empty
);
  // ****
  // One-cycle event pulses and buffer levels.
  // ****
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pulse    <= 7'h00;
      rx_full  <= 1'b0;
      tx_empty <= 1'b1;
    end
    else
    begin
      pulse    <= fire;
      rx_full  <= (rx_full | uart[0]) & ~uart[1];
      tx_empty <= (tx_empty | uart[2]) & ~uart[3];
    end
  end
endmodule

`default_nettype wire

// file: verification/epf_properties.sv
/*
  Port-level checker for epf_top.
  Assumes CORE_CE is held high.
*/
`default_nettype none

module epf_checker
  import epf_pkg::*;
#(
  parameter bit HAS_PARALLEL_PORT = 1'b1
)
(
  // Watched ports.
  input  wire logic          CORE_CLK,
  input  wire logic          NRST,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic [7:0]    PADDR,
  input  wire logic [31:0]   PRDATA,
  input  wire logic          PREADY,
  input  wire logic          PSLVERR,
  input  wire logic          RX_BUF_FULL,
  input  wire logic          TX_BUF_EMPTY,
  input  wire logic          PARPORT_ACCESS,
  input  wire logic          CONV_DONE,
  input  wire logic          SYNC_DONE,
  input  wire epf_cc_mode_t  CC_MODE,
  input  wire logic          CC_CAPTURE,
  input  wire logic          CC_MATCH,
  input  wire logic          PERIOD_MATCH,
  input  wire logic          TIMER_OVERFLOW,
  input  wire logic [7:0]    PERIPH_FLAGS_A
);
  // ****
  // Properties.
  // ****
  default clocking dc @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("PREADY held too long");
  wait_state_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("PREADY missing");
  err_map_a: assert property (PREADY |-> PSLVERR == $past(PADDR > 8'h0c))
    else $error("PSLVERR wrong");
  upper_zero_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("PRDATA upper bits set");
  live_bits_a: assert property (1 |=> PERIPH_FLAGS_A[5:4] == $past({RX_BUF_FULL, TX_BUF_EMPTY}))
    else $error("Buffer bits not live");
  parport_set_a: assert property (PARPORT_ACCESS |-> ##[1:2] PERIPH_FLAGS_A[7] == HAS_PARALLEL_PORT)
    else $error("Parallel flag wrong");
  conv_set_a: assert property (CONV_DONE |-> ##[1:2] PERIPH_FLAGS_A[6])
    else $error("Conversion flag not set");
  sync_set_a: assert property (SYNC_DONE |-> ##[1:2] PERIPH_FLAGS_A[3])
    else $error("Sync flag not set");
  capcmp_set_a: assert property (CC_MODE == EPF_CC_CAPTURE && CC_CAPTURE || CC_MODE == EPF_CC_COMPARE && CC_MATCH |-> ##[1:2] PERIPH_FLAGS_A[2])
    else $error("Capture flag not set");
  period_set_a: assert property (PERIOD_MATCH |-> ##[1:2] PERIPH_FLAGS_A[1])
    else $error("Period flag not set");
  timer_set_a: assert property (TIMER_OVERFLOW |-> ##[1:2] PERIPH_FLAGS_A[0])
    else $error("Timer flag not set");
  sticky_hold_a: assert property (!PSEL && !$past(PSEL) |=> (PERIPH_FLAGS_A & $past(PERIPH_FLAGS_A) & 8'hcf) == ($past(PERIPH_FLAGS_A) & 8'hcf))
    else $error("Flag lost without write");
  cover property (PSLVERR);
  cover property (PERIPH_FLAGS_A[2]);
  cover property (PERIPH_FLAGS_A[5]);
endmodule

bind epf_top epf_checker #(.HAS_PARALLEL_PORT(HAS_PARALLEL_PORT)) u_epf_checker
(
  .CORE_CLK, .NRST, .PSEL, .PENABLE, .PADDR, .PRDATA, .PREADY, .PSLVERR,
  .RX_BUF_FULL, .TX_BUF_EMPTY, .PARPORT_ACCESS, .CONV_DONE, .SYNC_DONE,
  .CC_MODE, .CC_CAPTURE, .CC_MATCH, .PERIOD_MATCH, .TIMER_OVERFLOW, .PERIPH_FLAGS_A
);

`default_nettype wire

// file: verification/ext_and_peripheral_irq_flags_tb.sv
/*
  Self-checking bench for epf_top over APB.
  Assumes the peripheral model and the bound checker.
*/
`default_nettype none

module ext_and_peripheral_irq_flags_tb;
  import epf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Signals and instances.
  // ****
  logic CORE_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, pa, pb, rx, tx, rh, rl;
  logic [7:0] PADDR, pf;
  logic [31:0] PWDATA, PRDATA;
  logic [3:0] strb, uart;
  logic [6:0] fire, pul;
  epf_cc_mode_t mode;
  int bad_count = 0;
  int n_checks = 0;
  logic [7:0] xm [7] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h04, 8'h02, 8'h01};
  epf_periph_model u_epf_periph_model (.clk(CORE_CLK), .nrst(NRST), .fire(fire),
    .uart(uart), .pulse(pul), .rx_full(rx), .tx_empty(tx));
  epf_top #(.HAS_PARALLEL_PORT(1'b1)) u_epf_top (.CORE_CLK(CORE_CLK), .CORE_CE(1'b1),
    .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(strb), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EXT_LINE_A_PIN(pa), .EXT_LINE_B_PIN(pb), .PARPORT_ACCESS(pul[6]), .CONV_DONE(pul[5]),
    .RX_BUF_FULL(rx), .TX_BUF_EMPTY(tx), .SYNC_DONE(pul[4]), .CC_MODE(mode),
    .CC_CAPTURE(pul[3]), .CC_MATCH(pul[2]), .PERIOD_MATCH(pul[1]),
    .TIMER_OVERFLOW(pul[0]), .EXT_REQ_HIGH(rh), .EXT_REQ_LOW(rl), .PERIPH_FLAGS_A(pf));
  initial
  begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  // ****
  // Tasks.
  // ****
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do
      @(posedge CORE_CLK);
    while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(nm, {24'h0, x}, r);
    chk("PSLVERR", {31'h0, xe}, {31'h0, e});
  endtask
  task automatic ev(input logic [6:0] m, input logic [3:0] u);
    @(posedge CORE_CLK);
    fire <= m;
    uart <= u;
    @(posedge CORE_CLK);
    fire <= 7'h00;
    uart <= 4'h0;
    repeat (2) @(posedge CORE_CLK);
  endtask
  task automatic rq(input logic h, input logic l);
    repeat (8) @(posedge CORE_CLK);
    #1;
    chk("EXT_REQ_HIGH", {31'h0, h}, {31'h0, rh});
    chk("EXT_REQ_LOW", {31'h0, l}, {31'h0, rl});
  endtask
  task automatic t_regs();
    rd("ctrl", 8'h00, 8'hc0, 1'b0);
    rd("bank_b", 8'h08, 8'h00, 1'b0);
    rd("unmapped", 8'h20, 8'h00, 1'b1);
    wr(8'h04, 8'hff);
    rd("bank_a", 8'h04, 8'hdf, 1'b0);
    strb <= 4'h0;
    wr(8'h04, 8'h00);
    strb <= 4'hf;
    rd("bank_a", 8'h04, 8'hdf, 1'b0);
    wr(8'h04, 8'h00);
    rd("bank_a", 8'h04, 8'h10, 1'b0);
  endtask
  task automatic t_flags();
    for (int i = 0; i < 7; i++)
    begin
      mode <= (i == 4) ? EPF_CC_COMPARE : EPF_CC_CAPTURE;
      ev(7'h40 >> i, 4'h0);
      rd("bank_a", 8'h04, xm[i] | 8'h10, 1'b0);
      wr(8'h04, 8'h00);
    end
    mode <= EPF_CC_PWM;
    ev(7'h0c, 4'h0);
    rd("bank_a", 8'h04, 8'h10, 1'b0);
    ev(7'h00, 4'h9);
    rd("bank_a", 8'h04, 8'h20, 1'b0);
    ev(7'h00, 4'h6);
    rd("bank_a", 8'h04, 8'h10, 1'b0);
  endtask
  task automatic t_ext();
    wr(8'h00, 8'h00);
    pa <= 1'b1;
    rq(1'b0, 1'b0);
    rd("ctrl", 8'h00, 8'h01, 1'b0);
    wr(8'h00, 8'h49);
    rq(1'b1, 1'b0);
    wr(8'h00, 8'h09);
    rq(1'b0, 1'b1);
    wr(8'h00, 8'h08);
    rq(1'b0, 1'b0);
    pb <= 1'b1;
    rq(1'b0, 1'b0);
    rd("ctrl", 8'h00, 8'h0a, 1'b0);
    rd("status", 8'h0c, 8'h03, 1'b0);
    wr(8'h00, 8'hff);
    rd("ctrl", 8'h00, 8'hdb, 1'b0);
  endtask
  // ****
  // Main sequence and watchdog.
  // ****
  initial
  begin
    {NRST, PSEL, PENABLE, PWRITE, pa, pb} = 6'h00;
    {PADDR, PWDATA, fire, uart} = '0;
    strb = 4'hf;
    mode = EPF_CC_OFF;
    repeat (8) @(posedge CORE_CLK);
    NRST <= 1'b1;
    t_regs();
    t_flags();
    t_ext();
    summarize();
  end
  initial
  begin
    #100us;
    bad_count++;
    summarize();
  end
endmodule

`default_nettype wire
